// *** inc/text_lcd_defs.vh ***
// constants for the character display command interpreter
// assumes a 20 x 4 character screen and byte-wide input from a same-clock receiver
`ifndef TEXT_LCD_DEFS_VH
`define TEXT_LCD_DEFS_VH

`define COLS          5'h14
`define ROWS          3'h4
`define LAST_COL      5'h13
`define LAST_ROW      2'h3
`define CELLS         7'h50
`define MSG_LEN       7'h50
`define BLANK         8'h20
`define PREFIX        8'hfe
`define NUM_BANKS     3'h5
`define BANK_STARTUP  3'h0
`define BANK_MEDIUM   3'h3
`define BANK_LARGE    3'h4
`define MAX_ID        8'h07

`define CMD_CLEAR     8'h58
`define CMD_MSG       8'h40
`define CMD_SCR_ON    8'h51
`define CMD_SCR_OFF   8'h52
`define CMD_WRAP_ON   8'h43
`define CMD_WRAP_OFF  8'h44
`define CMD_SETPOS    8'h47
`define CMD_HOME      8'h48
`define CMD_BACK      8'h4c
`define CMD_FWD       8'h4d
`define CMD_UL_ON     8'h4a
`define CMD_UL_OFF    8'h4b
`define CMD_BLK_ON    8'h53
`define CMD_BLK_OFF   8'h54
`define CMD_CREATE    8'h4e
`define CMD_SAVE      8'hc1
`define CMD_LOAD      8'hc0
`define CMD_SAVE_ST   8'hc2
`define CMD_INIT_MED  8'h6d
`define CMD_INIT_LRG  8'h6e
`define CMD_PUT_MED   8'h6f
`define CMD_PUT_LRG   8'h23

`define MED_H         3'h2
`define MED_W         2'h1
`define LRG_H         3'h4
`define LRG_W         2'h3
`define PIX_MASK      8'h1f

`endif

// *** src/screen_buffer.v ***
// character cell store for the 20 x 4 screen, one byte per cell
// assumes write, clear and scroll strobes are single-cycle pulses from the parser
`timescale 1ns/1ps
`include "text_lcd_defs.vh"

module screen_buffer (
   input  wire       clk_sys_i,
   input  wire       reset_n_i,
   input  wire       clr_i,
   input  wire       scroll_i,
   input  wire       wr_i,
   input  wire [6:0] wr_addr_i,
   input  wire [7:0] wr_data_i,
   input  wire [6:0] rd_addr_i,
   output reg  [7:0] rd_data_o
);

   reg [7:0] cell_q [0:79];
   integer   i;

   // clear beats scroll beats a plain write; a write in a scroll cycle
   // lands in the row it has just moved to, so the last character survives
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (i = 0; i < `CELLS; i = i + 1)
            cell_q[i] <= `BLANK;
      end else if (clr_i) begin
         for (i = 0; i < `CELLS; i = i + 1)
            cell_q[i] <= `BLANK;
      end else if (scroll_i) begin
         for (i = 0; i < `CELLS - `COLS; i = i + 1)
            cell_q[i] <= cell_q[i + `COLS];
         for (i = `CELLS - `COLS; i < `CELLS; i = i + 1)
            cell_q[i] <= `BLANK;
         if (wr_i && wr_addr_i >= `COLS)
            cell_q[wr_addr_i - {2'b00, `COLS}] <= wr_data_i;
      end else if (wr_i && wr_addr_i < `CELLS) begin
         cell_q[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read port; unmapped addresses read as blank
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         rd_data_o <= `BLANK;
      else if (rd_addr_i < `CELLS)
         rd_data_o <= cell_q[rd_addr_i];
      else
         rd_data_o <= `BLANK;
   end

endmodule // screen_buffer

// *** src/text_lcd_command_parser.v ***
// command interpreter for a 20 x 4 character display fed by a byte stream
// assumes bytes arrive from a receiver on clk_sys_i with a valid/ready handshake
`timescale 1ns/1ps
`include "text_lcd_defs.vh"

module text_lcd_command_parser (
   input  wire       clk_sys_i,
   input  wire       reset_n_i,
   input  wire       rx_valid_i,
   input  wire [7:0] rx_data_i,
   output reg        rx_ready_o,
   input  wire [6:0] scr_rd_addr_i,
   output wire [7:0] scr_rd_data_o,
   input  wire [6:0] msg_rd_addr_i,
   output reg  [7:0] msg_rd_data_o,
   input  wire [5:0] glyph_rd_addr_i,
   output reg  [4:0] glyph_rd_data_o,
   output reg  [4:0] cursor_col_o,
   output reg  [1:0] cursor_row_o,
   output reg        underline_o,
   output reg        blink_o,
   output reg        auto_scroll_o,
   output reg        line_wrap_o,
   output reg  [2:0] active_bank_o
);

   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_CMD    = 3'h1;
   localparam [2:0] ST_PARAM  = 3'h2;
   localparam [2:0] ST_MSG    = 3'h3;
   localparam [2:0] ST_EXEC   = 3'h4;
   localparam [2:0] ST_DRAW   = 3'h5;

   reg [2:0] state_q;
   reg [7:0] cmd_q;
   reg [3:0] pcnt_q;
   reg [3:0] pneed_q;
   reg [7:0] par_q [0:9];
   reg [6:0] mcnt_q;
   reg [7:0] msg_q [0:79];
   reg [4:0] act_q [0:63];
   reg [4:0] bank_q [0:319];
   reg       scr_wr_q;
   reg [6:0] scr_addr_q;
   reg [7:0] scr_data_q;
   reg       scr_clr_q;
   reg       scr_scroll_q;
   reg [4:0] d_col_q;
   reg [1:0] d_row_q;
   reg [2:0] d_h_q;
   reg [1:0] d_w_q;
   reg [2:0] d_r_q;
   reg [1:0] d_c_q;
   reg [3:0] d_digit_q;
   integer   i;

   wire       take = rx_valid_i & rx_ready_o;
   wire [2:0] p_bank = par_q[0][2:0];

   // parameter bytes each command carries; unknown commands take none
   function [3:0] param_count;
      input [7:0] c;
      begin
         case (c)
            `CMD_SETPOS:  param_count = 4'h2;
            `CMD_CREATE:  param_count = 4'h9;
            `CMD_SAVE:    param_count = 4'ha;
            `CMD_LOAD:    param_count = 4'h1;
            `CMD_SAVE_ST: param_count = 4'h9;
            `CMD_PUT_MED: param_count = 4'h3;
            `CMD_PUT_LRG: param_count = 4'h2;
            default:      param_count = 4'h0;
         endcase
      end
   endfunction

   // screen cell index of a row/column pair
   function [6:0] cell_idx;
      input [1:0] r;
      input [4:0] c;
      begin
         cell_idx = {1'b0, r, 4'h0} + {3'b000, r, 2'b00} + {2'b00, c};
      end
   endfunction

   // row that follows r when a row fills; wrap off walks 0,2,1,3
   function [1:0] next_row;
      input [1:0] r;
      input       wrap;
      begin
         if (wrap)
            next_row = r + 2'h1;
         else
            case (r)
               2'h0:    next_row = 2'h2;
               2'h2:    next_row = 2'h1;
               2'h1:    next_row = 2'h3;
               default: next_row = 2'h0;
            endcase
      end
   endfunction

   // row that precedes r in the same walking order
   function [1:0] prev_row;
      input [1:0] r;
      input       wrap;
      begin
         if (wrap)
            prev_row = r - 2'h1;
         else
            case (r)
               2'h2:    prev_row = 2'h0;
               2'h1:    prev_row = 2'h2;
               2'h3:    prev_row = 2'h1;
               default: prev_row = 2'h3;
            endcase
      end
   endfunction

   // glyph code for one cell of a drawn digit; glyph layout lives in the bank
   function [7:0] digit_code;
      input [3:0] d;
      input [2:0] r;
      input [1:0] c;
      input [1:0] w;
      reg   [4:0] k;
      begin
         k = {2'b00, r} * {3'b000, w} + {3'b000, c} + {1'b0, d};
         digit_code = {5'h00, k[2:0]};
      end
   endfunction

   // byte intake: prefix detection, parameter gathering, message capture
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_IDLE;
         cmd_q   <= 8'h00;
         pcnt_q  <= 4'h0;
         pneed_q <= 4'h0;
         mcnt_q  <= 7'h00;
         for (i = 0; i < 10; i = i + 1)
            par_q[i] <= 8'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take && rx_data_i == `PREFIX)
                  state_q <= ST_CMD;
            end
            ST_CMD: begin
               if (take) begin
                  cmd_q   <= rx_data_i;
                  pneed_q <= param_count(rx_data_i);
                  pcnt_q  <= 4'h0;
                  mcnt_q  <= 7'h00;
                  if (rx_data_i == `CMD_MSG)
                     state_q <= ST_MSG;
                  else if (param_count(rx_data_i) == 4'h0)
                     state_q <= ST_EXEC;
                  else
                     state_q <= ST_PARAM;
               end
            end
            ST_PARAM: begin
               if (take) begin
                  par_q[pcnt_q] <= rx_data_i;
                  pcnt_q        <= pcnt_q + 4'h1;
                  if (pcnt_q + 4'h1 == pneed_q)
                     state_q <= ST_EXEC;
               end
            end
            ST_MSG: begin
               if (take) begin
                  mcnt_q <= mcnt_q + 7'h01;
                  if (mcnt_q + 7'h01 == `MSG_LEN)
                     state_q <= ST_IDLE;
               end
            end
            ST_EXEC: begin
               if ((cmd_q == `CMD_PUT_MED || cmd_q == `CMD_PUT_LRG) && d_col_q < `COLS)
                  state_q <= ST_DRAW;
               else
                  state_q <= ST_IDLE;
            end
            ST_DRAW: begin
               if (d_r_q + 3'h1 == d_h_q && {1'b0, d_c_q} + 3'h1 == {1'b0, d_w_q})
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // intake stalls while a command executes or a digit is being drawn
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         rx_ready_o <= 1'b0;
      else
         rx_ready_o <= (state_q == ST_IDLE || state_q == ST_CMD || state_q == ST_MSG ||
                        (state_q == ST_PARAM && !(take && pcnt_q + 4'h1 == pneed_q))) &&
                       !(state_q == ST_CMD && take);
   end

   // start-up message bytes kept in order; codes 0..7 show bank 0 glyphs
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (i = 0; i < 80; i = i + 1)
            msg_q[i] <= `BLANK;
         msg_rd_data_o <= `BLANK;
      end else begin
         if (state_q == ST_MSG && take)
            msg_q[mcnt_q] <= rx_data_i;
         msg_rd_data_o <= (msg_rd_addr_i < `MSG_LEN) ? msg_q[msg_rd_addr_i] : `BLANK;
      end
   end

   // glyph memories: active set plus five stored banks of eight glyphs
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (i = 0; i < 64; i = i + 1)
            act_q[i] <= 5'h00;
         for (i = 0; i < 320; i = i + 1)
            bank_q[i] <= 5'h00;
         active_bank_o   <= `BANK_STARTUP;
         glyph_rd_data_o <= 5'h00;
      end else begin
         glyph_rd_data_o <= act_q[glyph_rd_addr_i];
         if (state_q == ST_EXEC) begin
            case (cmd_q)
               `CMD_CREATE: begin
                  if (par_q[0] <= `MAX_ID)
                     for (i = 0; i < 8; i = i + 1)
                        act_q[{par_q[0][2:0], 3'h0} + i[5:0]] <= par_q[i + 1][4:0];
               end
               `CMD_SAVE: begin
                  if (p_bank < `NUM_BANKS && par_q[0][7:3] == 5'h00 && par_q[1] <= `MAX_ID)
                     for (i = 0; i < 8; i = i + 1)
                        bank_q[{p_bank, par_q[1][2:0], 3'h0} + i[8:0]] <=
                           par_q[i + 2][4:0];
               end
               `CMD_SAVE_ST: begin
                  if (par_q[0] <= `MAX_ID)
                     for (i = 0; i < 8; i = i + 1)
                        bank_q[{`BANK_STARTUP, par_q[0][2:0], 3'h0} + i[8:0]] <=
                           par_q[i + 1][4:0];
               end
               `CMD_LOAD: begin
                  // a load replaces every active glyph, so created ones vanish
                  if (p_bank < `NUM_BANKS && par_q[0][7:3] == 5'h00) begin
                     active_bank_o <= p_bank;
                     for (i = 0; i < 64; i = i + 1)
                        act_q[i] <= bank_q[{p_bank, 6'h00} + i[8:0]];
                  end
               end
               `CMD_INIT_MED: begin
                  active_bank_o <= `BANK_MEDIUM;
                  for (i = 0; i < 64; i = i + 1)
                     act_q[i] <= bank_q[{`BANK_MEDIUM, 6'h00} + i[8:0]];
               end
               `CMD_INIT_LRG: begin
                  active_bank_o <= `BANK_LARGE;
                  for (i = 0; i < 64; i = i + 1)
                     act_q[i] <= bank_q[{`BANK_LARGE, 6'h00} + i[8:0]];
               end
               default: ;
            endcase
         end
      end
   end

   // mode flags and cursor style
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         auto_scroll_o <= 1'b1;
         line_wrap_o   <= 1'b1;
         underline_o   <= 1'b0;
         blink_o       <= 1'b0;
      end else if (state_q == ST_EXEC) begin
         case (cmd_q)
            `CMD_SCR_ON:  auto_scroll_o <= 1'b1;
            `CMD_SCR_OFF: auto_scroll_o <= 1'b0;
            `CMD_WRAP_ON: line_wrap_o   <= 1'b1;
            `CMD_WRAP_OFF: line_wrap_o  <= 1'b0;
            `CMD_UL_ON:   underline_o   <= 1'b1;
            `CMD_UL_OFF:  underline_o   <= 1'b0;
            `CMD_BLK_ON:  blink_o       <= 1'b1;
            `CMD_BLK_OFF: blink_o       <= 1'b0;
            default: ;
         endcase
      end
   end

   // digit draw set-up; cells walked row by row, one per cycle
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         d_col_q   <= 5'h00;
         d_row_q   <= 2'h0;
         d_h_q     <= `MED_H;
         d_w_q     <= `MED_W;
         d_r_q     <= 3'h0;
         d_c_q     <= 2'h0;
         d_digit_q <= 4'h0;
      end else if (state_q == ST_PARAM && take && pcnt_q + 4'h1 == pneed_q) begin
         d_r_q <= 3'h0;
         d_c_q <= 2'h0;
         if (cmd_q == `CMD_PUT_MED) begin
            d_col_q   <= par_q[0][4:0] - 5'h01;
            d_row_q   <= par_q[1][1:0] - 2'h1;
            d_digit_q <= rx_data_i[3:0];
            d_h_q     <= `MED_H;
            d_w_q     <= `MED_W;
         end else begin
            d_col_q   <= (pcnt_q == 4'h1) ? par_q[0][4:0] - 5'h01 : 5'h1f;
            d_row_q   <= 2'h0;
            d_digit_q <= rx_data_i[3:0];
            d_h_q     <= `LRG_H;
            d_w_q     <= `LRG_W;
         end
         if ((cmd_q == `CMD_PUT_MED && (par_q[0] == 8'h00 || par_q[0] > {3'h0, `COLS} ||
              par_q[1] == 8'h00 || par_q[1] > {5'h00, `ROWS})) ||
             (cmd_q == `CMD_PUT_LRG && (par_q[0] == 8'h00 || par_q[0] > {3'h0, `COLS})))
            d_col_q <= 5'h1f; // out-of-range position draws nothing
      end else if (state_q == ST_DRAW) begin
         if ({1'b0, d_c_q} + 3'h1 == {1'b0, d_w_q}) begin
            d_c_q <= 2'h0;
            d_r_q <= d_r_q + 3'h1;
         end else begin
            d_c_q <= d_c_q + 2'h1;
         end
      end
   end

   // cursor motion and screen write strobes
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cursor_col_o <= 5'h00;
         cursor_row_o <= 2'h0;
         scr_wr_q     <= 1'b0;
         scr_addr_q   <= 7'h00;
         scr_data_q   <= `BLANK;
         scr_clr_q    <= 1'b0;
         scr_scroll_q <= 1'b0;
      end else begin
         scr_wr_q     <= 1'b0;
         scr_clr_q    <= 1'b0;
         scr_scroll_q <= 1'b0;
         if (state_q == ST_IDLE && take && rx_data_i != `PREFIX) begin
            scr_wr_q   <= 1'b1;
            scr_addr_q <= cell_idx(cursor_row_o, cursor_col_o);
            scr_data_q <= rx_data_i;
            if (cursor_col_o != `LAST_COL) begin
               cursor_col_o <= cursor_col_o + 5'h01;
            end else begin
               cursor_col_o <= 5'h00;
               if (next_row(cursor_row_o, line_wrap_o) != 2'h0 &&
                   !(line_wrap_o && cursor_row_o == `LAST_ROW))
                  cursor_row_o <= next_row(cursor_row_o, line_wrap_o);
               else if (auto_scroll_o)
                  scr_scroll_q <= 1'b1;
               else
                  cursor_row_o <= 2'h0;
            end
         end else if (state_q == ST_EXEC) begin
            case (cmd_q)
               `CMD_CLEAR: scr_clr_q <= 1'b1;
               `CMD_HOME: begin
                  cursor_col_o <= 5'h00;
                  cursor_row_o <= 2'h0;
               end
               `CMD_SETPOS: begin
                  if (par_q[0] != 8'h00 && par_q[0] <= {3'h0, `COLS} &&
                      par_q[1] != 8'h00 && par_q[1] <= {5'h00, `ROWS}) begin
                     cursor_col_o <= par_q[0][4:0] - 5'h01;
                     cursor_row_o <= par_q[1][1:0] - 2'h1;
                  end
               end
               `CMD_FWD: begin
                  if (cursor_col_o != `LAST_COL) begin
                     cursor_col_o <= cursor_col_o + 5'h01;
                  end else begin
                     cursor_col_o <= 5'h00;
                     cursor_row_o <= next_row(cursor_row_o, line_wrap_o);
                  end
               end
               `CMD_BACK: begin
                  if (cursor_col_o != 5'h00) begin
                     cursor_col_o <= cursor_col_o - 5'h01;
                  end else begin
                     cursor_col_o <= `LAST_COL;
                     cursor_row_o <= prev_row(cursor_row_o, line_wrap_o);
                  end
               end
               default: ;
            endcase
         end else if (state_q == ST_DRAW) begin
            // cells past the right edge are dropped, not wrapped
            scr_wr_q   <= (d_col_q + {3'h0, d_c_q} < `COLS) &&
                          ({1'b0, d_row_q} + d_r_q < `ROWS);
            scr_addr_q <= cell_idx(d_row_q + d_r_q[1:0], d_col_q + {3'h0, d_c_q});
            scr_data_q <= digit_code(d_digit_q, d_r_q, d_c_q, d_w_q);
         end
      end
   end

   screen_buffer u_screen (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .clr_i     (scr_clr_q),
      .scroll_i  (scr_scroll_q),
      .wr_i      (scr_wr_q),
      .wr_addr_i (scr_addr_q),
      .wr_data_i (scr_data_q),
      .rd_addr_i (scr_rd_addr_i),
      .rd_data_o (scr_rd_data_o)
   );

endmodule // text_lcd_command_parser

// *** test/text_lcd_command_parser_chk.sv ***
// port checker for the display command interpreter
// assumes the bench never sends 0xfe as a parameter byte
`timescale 1ns/1ps
module text_lcd_command_parser_chk (
   input wire logic       clk_sys_i,
   input wire logic       reset_n_i,
   input wire logic       rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic       rx_ready_o,
   input wire logic [7:0] scr_rd_data_o,
   input wire logic [4:0] cursor_col_o,
   input wire logic [1:0] cursor_row_o,
   input wire logic       underline_o,
   input wire logic       blink_o,
   input wire logic       auto_scroll_o,
   input wire logic       line_wrap_o,
   input wire logic [2:0] active_bank_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   wire  take = rx_valid_i && rx_ready_o;
   logic pfx_q;
   // remembers a taken prefix so the next taken byte is a command code
   always @(posedge clk_sys_i or negedge reset_n_i)
      if (!reset_n_i) pfx_q <= 1'b0;
      else if (take) pfx_q <= (rx_data_i == 8'hfe);
   chk_clear_blank: assert property (take && pfx_q && rx_data_i == 8'h58 |-> ##4
      scr_rd_data_o == 8'h20) else $error("cell not blank after clear");
   chk_home_zero: assert property (take && pfx_q && rx_data_i == 8'h48 |-> ##[2:3]
      (cursor_col_o == 5'h00 && cursor_row_o == 2'h0)) else $error("home missed");
   chk_cmd_pause: assert property (take && pfx_q |=> !rx_ready_o)
      else $error("ready stayed high after command code");
   chk_scroll_gate: assert property ($changed(auto_scroll_o) |-> !$past(rx_ready_o))
      else $error("scroll mode moved outside a command");
   chk_wrap_gate: assert property ($changed(line_wrap_o) |-> !$past(rx_ready_o))
      else $error("wrap mode moved outside a command");
   chk_ul_gate: assert property ($changed(underline_o) |-> !$past(rx_ready_o))
      else $error("underline moved outside a command");
   chk_blk_gate: assert property ($changed(blink_o) |-> !$past(rx_ready_o))
      else $error("blink moved outside a command");
   chk_bank_gate: assert property ($changed(active_bank_o) |-> !$past(rx_ready_o))
      else $error("bank moved outside a command");
   chk_bank_range: assert property (active_bank_o <= 3'h4)
      else $error("bank above four");
   chk_col_range: assert property (cursor_col_o <= 5'h13)
      else $error("column past screen");
   cov_clear: cover property (take && pfx_q && rx_data_i == 8'h58);
   cov_home: cover property (take && pfx_q && rx_data_i == 8'h48);
   cov_bank: cover property ($changed(active_bank_o));
endmodule // text_lcd_command_parser_chk

bind text_lcd_command_parser text_lcd_command_parser_chk text_lcd_command_parser_chk_i (
   .clk_sys_i, .reset_n_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .scr_rd_data_o,
   .cursor_col_o, .cursor_row_o, .underline_o, .blink_o, .auto_scroll_o,
   .line_wrap_o, .active_bank_o);

// *** test/text_lcd_host.sv ***
// host model feeding bytes to the parser over valid/ready
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/1ps
module text_lcd_host (
   input  wire logic       clk_sys_i,
   input  wire logic       ready_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
   end
   // byte held until ready; ready is registered, so its falling-edge value
   // is what the next rising edge samples
   task send(input logic [7:0] b);
      logic r;
      rx_valid_o <= 1'b1;
      rx_data_o  <= b;
      do begin
         @(negedge clk_sys_i) r = ready_i;
         @(posedge clk_sys_i);
      end while (!r);
   endtask
   // released data shows the inverse so stale bytes are never mistaken
   task quiet(input int n);
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~rx_data_o;
      repeat (n) @(posedge clk_sys_i);
   endtask
endmodule // text_lcd_host

// *** test/text_lcd_command_parser_tb.sv ***
// self-checking bench for the display command interpreter
// assumes the host model and the bound checker compile alongside
`timescale 1ns/1ps
module text_lcd_command_parser_tb;
   logic       clk_sys_i;
   logic       reset_n_i;
   logic       rx_valid_i;
   logic [7:0] rx_data_i;
   logic       rx_ready_o;
   logic [6:0] scr_rd_addr;
   logic [6:0] msg_rd_addr;
   logic [5:0] glyph_rd_addr;
   logic [7:0] scr_d;
   logic [7:0] msg_d;
   logic [4:0] glyph_d;
   logic [4:0] col;
   logic [1:0] row;
   logic       ul;
   logic       blk;
   logic       scroll;
   logic       wrap;
   logic [2:0] bank;
   int         n_errors = 0;
   int         compares = 0;
   int         cyc = 0;
   text_lcd_command_parser text_lcd_command_parser_i (
      .clk_sys_i, .reset_n_i, .rx_valid_i, .rx_data_i, .rx_ready_o,
      .scr_rd_addr_i(scr_rd_addr), .scr_rd_data_o(scr_d),
      .msg_rd_addr_i(msg_rd_addr), .msg_rd_data_o(msg_d),
      .glyph_rd_addr_i(glyph_rd_addr), .glyph_rd_data_o(glyph_d),
      .cursor_col_o(col), .cursor_row_o(row), .underline_o(ul), .blink_o(blk),
      .auto_scroll_o(scroll), .line_wrap_o(wrap), .active_bank_o(bank));
   text_lcd_host text_lcd_host_i (
      .clk_sys_i, .ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   // a hang is cut short well past the few hundred cycles the tests need
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("timeout at cycle %0d", cyc);
         end_sim();
      end
   end
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tx(input logic [7:0] b); text_lcd_host_i.send(b); endtask
   task wt(input int n); text_lcd_host_i.quiet(n); endtask
   task cmd(input logic [7:0] c); tx(8'hfe); tx(c); endtask
   task pos(input logic [7:0] c, input logic [7:0] r); cmd(8'h47); tx(c); tx(r); endtask
   task rows(input logic [7:0] v); repeat (8) tx(v); endtask
   task load(input logic [7:0] b); cmd(8'hc0); tx(b); wt(3); endtask
   task at(input logic [1:0] r, input logic [4:0] c);
      chk("row", 8'(row), 8'(r));
      chk("col", 8'(col), 8'(c));
   endtask
   // read latency is one cycle, so two edges with the address held suffice
   task peek(input logic [6:0] a);
      scr_rd_addr   <= a;
      msg_rd_addr   <= a;
      glyph_rd_addr <= a[5:0];
      repeat (2) @(posedge clk_sys_i);
   endtask
   task t_text;
      tx(8'h41);
      tx(8'h42);
      wt(3);
      at(2'h0, 5'h02);
      peek(7'h00);
      chk("cell0", scr_d, 8'h41);
      peek(7'h01);
      chk("cell1", scr_d, 8'h42);
      $display("done text");
   endtask
   task t_pos;
      pos(8'h05, 8'h03);
      tx(8'h58);
      wt(3);
      peek(7'h2c);
      chk("cell44", scr_d, 8'h58);
      cmd(8'h48); wt(3); at(2'h0, 5'h00);
      cmd(8'h4d); wt(3); at(2'h0, 5'h01);
      cmd(8'h4c); wt(3); at(2'h0, 5'h00);
      cmd(8'h44); cmd(8'h4c); wt(3); at(2'h3, 5'h13);
      cmd(8'h4d); wt(3); at(2'h0, 5'h00);
      $display("done position");
   endtask
   task t_modes;
      logic [7:0] c [8] = '{8'h4a, 8'h53, 8'h4b, 8'h54, 8'h52, 8'h44, 8'h51, 8'h43};
      logic [3:0] e [8] = '{4'hb, 4'hf, 4'h7, 4'h3, 4'h1, 4'h0, 4'h2, 4'h3};
      chk("reset modes", 8'({ul, blk, scroll, wrap, bank}), 8'h18);
      for (int i = 0; i < 8; i++) begin
         cmd(c[i]);
         wt(3);
         chk("modes", 8'({ul, blk, scroll, wrap}), 8'(e[i]));
      end
      $display("done modes");
   endtask
   task t_wrap;
      cmd(8'h44); pos(8'h14, 8'h01); tx(8'h71); wt(3); at(2'h2, 5'h00);
      cmd(8'h43); pos(8'h14, 8'h01); tx(8'h71); wt(3); at(2'h1, 5'h00);
      $display("done wrap");
   endtask
   task t_scroll;
      pos(8'h14, 8'h04); tx(8'h5a); wt(4); at(2'h3, 5'h00);
      peek(7'h3b);
      chk("scrolled", scr_d, 8'h5a);
      cmd(8'h52); pos(8'h14, 8'h04); tx(8'h59); wt(3); at(2'h0, 5'h00);
      cmd(8'h51); wt(3);
      $display("done scroll");
   endtask
   task t_clear;
      cmd(8'h58);
      wt(4);
      peek(7'h3b);
      chk("clear59", scr_d, 8'h20);
      peek(7'h2c);
      chk("clear44", scr_d, 8'h20);
      $display("done clear");
   endtask
   task t_glyph;
      cmd(8'h4e); tx(8'h02); rows(8'h05); wt(3); peek(7'h10);
      chk("create", 8'(glyph_d), 8'h05);
      load(8'h00); peek(7'h10);
      chk("discard", 8'(glyph_d), 8'h00);
      cmd(8'hc1); tx(8'h00); tx(8'h02); rows(8'h0a); load(8'h00); peek(7'h10);
      chk("saved", 8'(glyph_d), 8'h0a);
      cmd(8'hc2); tx(8'h03); rows(8'h11); load(8'h00); peek(7'h18);
      chk("startup", 8'(glyph_d), 8'h11);
      cmd(8'h6d); wt(3); chk("med", 8'(bank), 8'h03);
      cmd(8'h6e); wt(3); chk("large", 8'(bank), 8'h04);
      load(8'h01); chk("bank1", 8'(bank), 8'h01);
      load(8'h05); chk("bank5", 8'(bank), 8'h01);
      $display("done glyphs");
   endtask
   // large digit 0 at column 1, then medium digit 1 at column 5 row 2
   task t_digit;
      cmd(8'h6e); cmd(8'h23); tx(8'h01); tx(8'h00); wt(16);
      peek(7'h3e);
      chk("large", scr_d, 8'h03);
      peek(7'h03);
      chk("large edge", scr_d, 8'h20);
      cmd(8'h6d); cmd(8'h6f); tx(8'h05); tx(8'h02); tx(8'h01); wt(6);
      peek(7'h18);
      chk("medium top", scr_d, 8'h01);
      peek(7'h2c);
      chk("medium low", scr_d, 8'h02);
      peek(7'h40);
      chk("medium edge", scr_d, 8'h20);
      $display("done digits");
   endtask
   task t_msg;
      cmd(8'h40);
      for (int i = 0; i < 80; i++) tx(8'h30 + 8'(i));
      wt(3);
      peek(7'h00);
      chk("msg0", msg_d, 8'h30);
      peek(7'h4f);
      chk("msg79", msg_d, 8'h7f);
      $display("done message");
   endtask
   task end_sim;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      reset_n_i     = 1'b0;
      scr_rd_addr   = 7'h00;
      msg_rd_addr   = 7'h00;
      glyph_rd_addr = 6'h00;
      repeat (16) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      t_modes();
      t_text();
      t_pos();
      t_wrap();
      t_scroll();
      t_clear();
      t_glyph();
      t_digit();
      t_msg();
      end_sim();
   end
endmodule // text_lcd_command_parser_tb
